// ===== hhfs_engine_model.sv
// serial engine stand-in: pops transmit bytes, pushes receive bytes
`timescale 1ns/1ps
module hhfs_engine_model (
  // clock
  input  wire logic            ref_clk_i,
  // bench control
  input  wire logic [1:0]      pop_en_i,
  // transmit side
  input  wire logic [1:0][7:0] tx_data_i,
  input  wire logic [1:0]      tx_valid_i,
  input  wire logic [1:0]      tx_last_i,
  output logic      [1:0]      tx_pop_o,
  output logic      [1:0]      tx_sent_o,
  // receive side
  output logic      [1:0]      rx_push_o,
  output logic      [1:0][7:0] rx_data_o,
  output logic      [1:0]      rx_first_o,
  output logic      [1:0]      rx_end_o,
  output logic      [1:0]      rx_crc_bad_o,
  output logic      [1:0]      rx_abort_o
);
  logic [8:0]      got_q [$];
  logic [1:0]      phase, v, l;
  logic [1:0][7:0] d;

  initial begin
    {tx_pop_o, tx_sent_o, rx_push_o, rx_first_o, rx_end_o, rx_crc_bad_o, rx_abort_o, phase} = '0;
    rx_data_o = '0;
  end

  // sample at the edge, answer just after; pops only every fourth cycle, a slow engine
  always @(posedge ref_clk_i) begin
    v = tx_valid_i;
    l = tx_last_i;
    d = tx_data_i;
    #1;
    for (int c = 0; c < 2; c++) begin
      if (v[c]) begin
        got_q.push_back({c[0], d[c]});
      end
      tx_sent_o[c] = v[c] & l[c];
      tx_pop_o[c] = pop_en_i[c] & (phase == 2'h0);
    end
    phase = phase + 2'h1;
  end

  // one receive byte; afterwards data shows the inverse so stale values never match
  task automatic push(input int c, input logic [7:0] b, input logic f, e, cb, ab);
    @(posedge ref_clk_i);
    #1;
    rx_push_o[c] = 1'b1;
    rx_data_o[c] = b;
    rx_first_o[c] = f;
    rx_end_o[c] = e;
    rx_crc_bad_o[c] = e & cb;
    rx_abort_o[c] = e & ab;
    @(posedge ref_clk_i);
    #1;
    rx_push_o[c] = 1'b0;
    rx_data_o[c] = ~b;
    rx_first_o[c] = 1'b0;
    rx_end_o[c] = 1'b0;
  endtask
endmodule

// ===== hhfs_mem.sv
// simple dual port storage with registered read data
`timescale 1ns/1ps
module hhfs_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // clock
  input  wire logic ref_clk_i,
  // storage ports
  hhfs_mem_if.mem   port
);
  logic [DW-1:0] cells [2**AW];

  // ----------------------------------------------------------------
  // write and registered read
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (port.we) begin
      cells[port.waddr] <= port.wdata;
    end
  end

  // no reset on read data: it only matters one cycle after a read
  always_ff @(posedge ref_clk_i) begin
    if (port.re) begin
      port.rdata <= cells[port.raddr];
    end
  end
endmodule

// ===== hhfs_mem_if.sv
// port bundle between the fifo logic and its storage
`timescale 1ns/1ps
interface hhfs_mem_if #(
  parameter int AW = 7,
  parameter int DW = 8
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic          re;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
  modport mem  (input we, waddr, wdata, re, raddr, output rdata);
endinterface

// ===== hhfs_pkg.sv
// constants shared by the hdlc host fifo status block
package hhfs_pkg;

  // ----------------------------------------------------------------
  // register offsets, one entry per controller except the shared event offset and the reset value
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS    [2] = '{8'h20, 8'h22};
  localparam logic [7:0] OFF_MASK      [2] = '{8'h21, 8'h23};
  localparam logic [7:0] OFF_PKT_INFO  [2] = '{8'h2E, 8'h2F};
  localparam logic [7:0] OFF_RX_COUNT  [2] = '{8'h9C, 8'hAC};
  localparam logic [7:0] OFF_TX_PORT   [2] = '{8'h9D, 8'hAD};
  localparam logic [7:0] OFF_RX_PORT   [2] = '{8'h9E, 8'hAE};
  localparam logic [7:0] OFF_TX_SPACE  [2] = '{8'h9F, 8'hAF};
  localparam logic [7:0] OFF_EVENT     = 8'h2D;
  localparam logic [7:0] REG_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST_TNF   = 0;
  localparam int ST_TX_BELOW_LOW_MARK  = 1;
  localparam int ST_RNE   = 2;
  localparam int ST_RX_ABOVE_HIGH_MARK  = 3;
  localparam int ST_RPS   = 4;
  localparam int ST_RPE   = 5;
  localparam int ST_TX_MESSAGE_DONE_EVENT = 6;
  localparam int INFO_RX_FIFO_IS_EMPTY = 3;
  localparam int INFO_TX_FIFO_IS_FULL  = 4;
  localparam int INFO_TX_FIFO_IS_EMPTY = 5;
  localparam int MS_BIT      = 7;

  // ----------------------------------------------------------------
  // fifo geometry and packet status codes
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 128;
  localparam int SHORT_MAX  = 3;
  localparam logic [6:0] COUNT_CAP = 7'h7F;
  localparam logic [2:0] PS_PROGRESS = 3'h0;
  localparam logic [2:0] PS_OK       = 3'h1;
  localparam logic [2:0] PS_CRC      = 3'h2;
  localparam logic [2:0] PS_ABORT    = 3'h3;
  localparam logic [2:0] PS_OVERRUN  = 3'h4;
  localparam logic [2:0] PS_SHORT    = 3'h5;

endpackage

// ===== hhfs_top.sv
// host side fifo, status and event registers of the two hdlc controllers
`timescale 1ns/1ps

module hhfs_top
  import hhfs_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire  logic            ref_clk_i,
  input  wire  logic            rst_i,
  // host register port
  input  wire  logic [7:0]      addr_i,
  input  wire  logic            wr_i,
  input  wire  logic            rd_i,
  input  wire  logic [7:0]      wdata_i,
  output logic       [7:0]      rdata_o,
  output logic                  rd_valid_o,
  output logic                  int_n_o,
  // per controller settings
  input  wire  logic [1:0]      tx_end_mark_i,
  input  wire  logic [1:0][7:0] tx_low_mark_i,
  input  wire  logic [1:0][7:0] rx_high_mark_i,
  // transmit engine side
  input  wire  logic [1:0]      tx_pop_i,
  input  wire  logic [1:0]      tx_msg_sent_i,
  output logic       [1:0][7:0] tx_data_o,
  output logic       [1:0]      tx_last_o,
  output logic       [1:0]      tx_valid_o,
  output logic       [1:0]      tx_abort_o,
  // receive engine side
  input  wire  logic [1:0]      rx_push_i,
  input  wire  logic [1:0][7:0] rx_data_i,
  input  wire  logic [1:0]      rx_first_i,
  input  wire  logic [1:0]      rx_end_i,
  input  wire  logic [1:0]      rx_crc_bad_i,
  input  wire  logic [1:0]      rx_abort_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = 12;
  localparam logic [AW:0] FULL_LVL = (AW+1)'(DEPTH);

  // ----------------------------------------------------------------
  // per controller state visible to the register mux
  // ----------------------------------------------------------------
  logic [6:0] status_q     [2];
  logic [6:0] mask_r       [2];
  logic [7:0] info_q       [2];
  logic [7:0] rx_count_q   [2];
  logic [7:0] tx_space_q   [2];
  logic [7:0] rx_word_q    [2];
  logic [1:0] first_next_q;
  logic [1:0] underrun_r;
  logic [1:0] irq_q;
  logic [1:0] rx_rd_pend_r;

  // ----------------------------------------------------------------
  // read snapshot stage
  // ----------------------------------------------------------------
  logic       rd_stage_r;
  logic       rd_fifo_r;
  logic       rd_fifo_ch_r;
  logic [7:0] rd_snap_r;
  logic [7:0] rd_snap_nxt;
  logic       event_rd;

  assign event_rd = rd_i && (addr_i == OFF_EVENT);

  // register values are frozen in the cycle of the read so a clear loses nothing
  always_comb begin
    rd_snap_nxt = REG_RESET;
    if (event_rd) begin
      rd_snap_nxt = {4'h0, underrun_r[1], first_next_q[1], underrun_r[0], first_next_q[0]};
    end
    for (int c = 0; c < 2; c++) begin
      if (addr_i == OFF_STATUS[c]) begin
        rd_snap_nxt = {1'b0, status_q[c]};
      end
      if (addr_i == OFF_MASK[c]) begin
        rd_snap_nxt = {1'b0, mask_r[c]};
      end
      if (addr_i == OFF_PKT_INFO[c]) begin
        rd_snap_nxt = info_q[c];
      end
      if (addr_i == OFF_RX_COUNT[c]) begin
        rd_snap_nxt = rx_count_q[c];
      end
      if (addr_i == OFF_TX_SPACE[c]) begin
        rd_snap_nxt = tx_space_q[c];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_stage_r   <= 1'b0;
      rd_fifo_r    <= 1'b0;
      rd_fifo_ch_r <= 1'b0;
      rd_snap_r    <= REG_RESET;
    end else begin
      rd_stage_r   <= rd_i;
      rd_fifo_r    <= rd_i && (addr_i == OFF_RX_PORT[0] || addr_i == OFF_RX_PORT[1]);
      rd_fifo_ch_r <= (addr_i == OFF_RX_PORT[1]);
      rd_snap_r    <= rd_snap_nxt;
    end
  end

  // receive data comes from storage one cycle late, so every read answers in two
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o    <= REG_RESET;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_stage_r;
      if (rd_stage_r) begin
        rdata_o <= rd_fifo_r ? rx_word_q[rd_fifo_ch_r] : rd_snap_r;
      end
    end
  end

  // shared active low interrupt
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      int_n_o <= 1'b1;
    end else begin
      int_n_o <= ~(|irq_q);
    end
  end

  // ----------------------------------------------------------------
  // one controller
  // ----------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_ctrl
    hhfs_mem_if #(.AW(AW), .DW(9))  txm ();
    hhfs_mem_if #(.AW(AW), .DW(12)) rxm ();
    hhfs_mem_if #(.AW(AW), .DW(LW)) lqm ();

    hhfs_mem #(.AW(AW), .DW(9))  u_tx  (.ref_clk_i(ref_clk_i), .port(txm));
    hhfs_mem #(.AW(AW), .DW(12)) u_rx  (.ref_clk_i(ref_clk_i), .port(rxm));
    hhfs_mem #(.AW(AW), .DW(LW)) u_len (.ref_clk_i(ref_clk_i), .port(lqm));

    logic [AW-1:0] twp_r, trp_r, rwp_r, rrp_r, lwp_r, lrp_r;
    logic [AW:0]   tlvl_r, rlvl_r, lqc_r;
    logic          t_wr, t_rd, r_wr, r_rd, r_full_push, l_rd;
    logic          drop_r, ovr_r, hd_valid_r, hd_fetch_r, rx_rd_r;
    logic [LW-1:0] mlen_r, hd_len_r, hd_done_r, hd_left;
    logic [2:0]    end_code, pkt_status_r;
    logic [3:0]    cond, cond_d_r, cpend_r;
    logic [2:0]    ev_r;
    logic          st_rd;

    assign st_rd       = rd_i && (addr_i == OFF_STATUS[c]);
    assign t_wr        = wr_i && (addr_i == OFF_TX_PORT[c]) && (tlvl_r != FULL_LVL);
    assign t_rd        = tx_pop_i[c] && (tlvl_r != '0);
    assign r_full_push = rx_push_i[c] && !drop_r && (rlvl_r == FULL_LVL);
    assign r_wr        = rx_push_i[c] && !drop_r && (rlvl_r != FULL_LVL);
    assign r_rd        = rd_i && (addr_i == OFF_RX_PORT[c]) && (rlvl_r != '0);
    assign l_rd        = !hd_valid_r && !hd_fetch_r && (lqc_r != '0);
    assign hd_left     = hd_len_r - hd_done_r;

    // end code: abort beats short beats crc error
    always_comb begin
      end_code = PS_PROGRESS;
      if (rx_end_i[c]) begin
        if (rx_abort_i[c]) begin
          end_code = PS_ABORT;
        end else if (mlen_r + 1'b1 <= LW'(SHORT_MAX)) begin
          end_code = PS_SHORT;
        end else if (rx_crc_bad_i[c]) begin
          end_code = PS_CRC;
        end else begin
          end_code = PS_OK;
        end
      end
    end

    // storage ports
    assign txm.we    = t_wr;
    assign txm.waddr = twp_r;
    assign txm.wdata = {tx_end_mark_i[c], wdata_i};
    assign txm.re    = t_rd;
    assign txm.raddr = trp_r;
    assign rxm.we    = r_wr;
    assign rxm.waddr = rwp_r;
    assign rxm.wdata = {end_code, rx_first_i[c], rx_data_i[c]};
    assign rxm.re    = r_rd;
    assign rxm.raddr = rrp_r;
    assign lqm.we    = r_wr && rx_end_i[c];
    assign lqm.waddr = lwp_r;
    assign lqm.wdata = mlen_r + 1'b1;
    assign lqm.re    = l_rd;
    assign lqm.raddr = lrp_r;

    // transmit pointers and level
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        twp_r  <= '0;
        trp_r  <= '0;
        tlvl_r <= '0;
      end else begin
        twp_r  <= twp_r + AW'(t_wr);
        trp_r  <= trp_r + AW'(t_rd);
        tlvl_r <= tlvl_r + (AW+1)'(t_wr) - (AW+1)'(t_rd);
      end
    end

    // bytes to the engine; running dry mid message is an underrun
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        tx_valid_o[c] <= 1'b0;
        tx_abort_o[c] <= 1'b0;
        underrun_r[c] <= 1'b0;
      end else begin
        tx_valid_o[c] <= t_rd;
        tx_abort_o[c] <= tx_valid_o[c] && !txm.rdata[8] && (tlvl_r == '0);
        if (tx_valid_o[c] && !txm.rdata[8] && (tlvl_r == '0)) begin
          underrun_r[c] <= 1'b1;
        end else if (event_rd) begin
          underrun_r[c] <= 1'b0;
        end
      end
    end
    assign tx_data_o[c] = txm.rdata[7:0];
    assign tx_last_o[c] = txm.rdata[8];

    // receive pointers, length queue and overrun discard
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        rwp_r  <= '0;
        rrp_r  <= '0;
        rlvl_r <= '0;
        lwp_r  <= '0;
        lrp_r  <= '0;
        lqc_r  <= '0;
        mlen_r <= '0;
        drop_r <= 1'b0;
        ovr_r  <= 1'b0;
      end else begin
        rwp_r  <= rwp_r + AW'(r_wr);
        rrp_r  <= rrp_r + AW'(r_rd);
        rlvl_r <= rlvl_r + (AW+1)'(r_wr) - (AW+1)'(r_rd);
        lwp_r  <= lwp_r + AW'(lqm.we);
        lrp_r  <= lrp_r + AW'(l_rd);
        lqc_r  <= lqc_r + (AW+1)'(lqm.we) - (AW+1)'(l_rd);
        if (r_wr) begin
          mlen_r <= rx_end_i[c] ? '0 : (rx_first_i[c] ? LW'(1) : mlen_r + 1'b1);
        end
        // rest of an overrun packet is thrown away up to and including the next opening byte
        if (r_full_push) begin
          drop_r <= 1'b1;
          ovr_r  <= 1'b1;
          mlen_r <= '0;
        end else if (rx_push_i[c] && rx_first_i[c] && rlvl_r != FULL_LVL) begin
          drop_r <= 1'b0;
          if (drop_r) begin
            mlen_r <= LW'(1);
          end
        end
        if (rx_rd_r && rxm.rdata[11:9] == PS_PROGRESS && rlvl_r == '0 && ovr_r) begin
          ovr_r <= 1'b0;
        end
      end
    end

    // head message length for the readable count
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        hd_valid_r <= 1'b0;
        hd_fetch_r <= 1'b0;
        hd_len_r   <= '0;
        hd_done_r  <= '0;
        rx_rd_r    <= 1'b0;
      end else begin
        rx_rd_r    <= r_rd;
        hd_fetch_r <= l_rd;
        if (hd_fetch_r) begin
          hd_len_r   <= lqm.rdata;
          hd_valid_r <= 1'b1;
        end
        // an overrun packet has no end byte, so the read that empties the fifo restarts the count
        if (rx_rd_r && (rxm.rdata[11:9] != PS_PROGRESS || (ovr_r && rlvl_r == '0))) begin
          hd_valid_r <= 1'b0;
          hd_done_r  <= '0;
        end else if (r_rd) begin
          hd_done_r <= hd_done_r + 1'b1;
        end
      end
    end

    // port answer takes the storage register as it stands; one more stage would return the byte before
    assign rx_word_q[c] = rxm.rdata[7:0];

    // status as of the last fifo read, and the opening byte flag
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        pkt_status_r    <= PS_PROGRESS;
        first_next_q[c] <= 1'b0;
      end else begin
        if (rx_rd_r) begin
          if (rxm.rdata[11:9] != PS_PROGRESS) begin
            pkt_status_r <= rxm.rdata[11:9];
          end else if (ovr_r && rlvl_r == '0) begin
            pkt_status_r <= PS_OVERRUN;
          end else begin
            pkt_status_r <= PS_PROGRESS;
          end
        end
        if (r_wr && rx_first_i[c] && rlvl_r == '0) begin
          first_next_q[c] <= 1'b1;
        end else if (rx_rd_r) begin
          first_next_q[c] <= (rxm.rdata[11:9] != PS_PROGRESS) && (rlvl_r != '0);
        end
      end
    end

    // conditions, latched events and mask
    assign cond = {rlvl_r > (AW+1)'(rx_high_mark_i[c]), rlvl_r != '0,
                   tlvl_r < (AW+1)'(tx_low_mark_i[c]), tlvl_r != FULL_LVL};

    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        mask_r[c] <= 7'h00;
      end else if (wr_i && addr_i == OFF_MASK[c]) begin
        mask_r[c] <= wdata_i[6:0];
      end
    end

    // a new event in the cycle of the clearing read stays set
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        cond_d_r <= 4'h0;
        cpend_r  <= 4'h0;
        ev_r     <= 3'h0;
      end else begin
        cond_d_r <= cond;
        cpend_r  <= (cpend_r & ~{4{st_rd}}) | (cond & ~cond_d_r & mask_r[c][3:0]);
        ev_r[0]  <= (ev_r[0] & ~st_rd) | (r_wr && rx_first_i[c]);
        ev_r[1]  <= (ev_r[1] & ~st_rd) | (r_wr && rx_end_i[c]) | r_full_push;
        ev_r[2]  <= (ev_r[2] & ~st_rd) | tx_msg_sent_i[c];
      end
    end

    // status read from the live bits: a one-cycle-old image would let a clearing read swallow a fresh event
    assign status_q[c] = {ev_r, cond};

    // register images, all from flops
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        info_q[c]     <= REG_RESET;
        rx_count_q[c] <= REG_RESET;
        tx_space_q[c] <= REG_RESET;
        irq_q[c]      <= 1'b0;
      end else begin
        irq_q[c]    <= (|cpend_r) || (|(ev_r & mask_r[c][6:4]));
        info_q[c]   <= {2'b00, tlvl_r == '0, tlvl_r == FULL_LVL, rlvl_r == '0, pkt_status_r};
        tx_space_q[c] <= 8'(FULL_LVL - tlvl_r);
        if (hd_valid_r) begin
          rx_count_q[c] <= {1'b0, (hd_left > LW'(COUNT_CAP)) ? COUNT_CAP : hd_left[6:0]};
        end else if (!hd_fetch_r && lqc_r == '0) begin
          rx_count_q[c] <= {1'b1, (rlvl_r > (AW+1)'(COUNT_CAP)) ? COUNT_CAP : rlvl_r[6:0]};
        end else begin
          rx_count_q[c] <= 8'h80;
        end
      end
    end
  end

endmodule

// ===== hhfs_top_properties.sv
// checker of host port and engine port timing of the fifo status block
`timescale 1ns/1ps
module hhfs_top_chk
  import hhfs_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  // host port
  input wire logic [7:0] addr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rd_valid_o,
  input wire logic       int_n_o,
  // engine port
  input wire logic [1:0] tx_pop_i,
  input wire logic [1:0] tx_valid_o,
  input wire logic [1:0] tx_last_o,
  input wire logic [1:0] tx_abort_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  chk_read_answer: assert property (rd_i |-> ##2 rd_valid_o) else $error("read not answered");
  chk_answer_cause: assert property (rd_valid_o |-> $past(rd_i, 2)) else $error("answer without read");
  chk_unmapped_zero: assert property (rd_i && addr_i == 8'h00 |-> ##2 rdata_o == 8'h00)
    else $error("unmapped read not zero");
  // a one-cycle reset drops rdata without an answer, so skip that edge
  chk_rdata_hold: assert property (!rd_valid_o && !$past(rst_i) |-> $stable(rdata_o))
    else $error("read data moved without answer");
  chk_int_idle: assert property ($fell(rst_i) |-> int_n_o [*3]) else $error("interrupt after reset");
  chk_valid_cause0: assert property (tx_valid_o[0] |-> $past(tx_pop_i[0])) else $error("tx valid 0");
  chk_valid_cause1: assert property (tx_valid_o[1] |-> $past(tx_pop_i[1])) else $error("tx valid 1");
  chk_abort_cause0: assert property (tx_abort_o[0] |-> $past(tx_valid_o[0]) && !$past(tx_last_o[0]))
    else $error("abort 0 without underrun");
  chk_abort_cause1: assert property (tx_abort_o[1] |-> $past(tx_valid_o[1]) && !$past(tx_last_o[1]))
    else $error("abort 1 without underrun");
  chk_no_abort_last: assert property (tx_valid_o[0] && tx_last_o[0] |=> !tx_abort_o[0])
    else $error("abort after message end");
  cover property (tx_abort_o[1]);
  cover property (!int_n_o);
  cover property (rd_valid_o && rdata_o == 8'h2C);
endmodule

bind hhfs_top hhfs_top_chk #(.DEPTH(DEPTH)) hhfs_top_chk_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rd_valid_o(rd_valid_o), .int_n_o(int_n_o),
  .tx_pop_i(tx_pop_i), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o), .tx_abort_o(tx_abort_o));

// ===== tb_top.sv
// self-checking bench for the hdlc host fifo status block
`timescale 1ns/1ps
module tb_top;
  import hhfs_pkg::*;
  // ------------------------------------------------------------
  // signals and case tables
  // ------------------------------------------------------------
  logic            ref_clk_i, rst_i, wr_i, rd_i, rd_valid_o, int_n_o;
  logic [7:0]      addr_i, wdata_i, rdata_o, rv;
  logic [1:0]      tx_end_mark_i, pop_en, tx_pop_i, tx_msg_sent_i, tx_last_o, tx_valid_o, tx_abort_o;
  logic [1:0]      rx_push_i, rx_first_i, rx_end_i, rx_crc_bad_i, rx_abort_i;
  logic [1:0][7:0] tx_data_o, rx_data_i;
  int              fails;
  int              checks_done;
  int              aborts = 0;
  // address beside value expected after reset
  logic [15:0]     rows [9] = '{16'h2100, 16'h2300, 16'h2D00, 16'h2E28, 16'h2F28, 16'h9F80, 16'hAF80,
                                16'h9C80, 16'h0000};
  // length, crc bad, abort, expected packet status
  logic [12:0]     pkts [6] = '{{8'd5, 2'b00, PS_OK},
                                {8'd5, 2'b10, PS_CRC},
                                {8'd5, 2'b01, PS_ABORT},
                                {8'd3, 2'b00, PS_SHORT},
                                {8'd4, 2'b00, PS_OK},
                                {8'd2, 2'b11, PS_ABORT}};

  hhfs_top hhfs_top_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .rd_valid_o(rd_valid_o), .int_n_o(int_n_o),
    .tx_end_mark_i(tx_end_mark_i), .tx_low_mark_i(16'h0000), .rx_high_mark_i(16'hFFFF),
    .tx_pop_i(tx_pop_i), .tx_msg_sent_i(tx_msg_sent_i), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
    .tx_valid_o(tx_valid_o), .tx_abort_o(tx_abort_o), .rx_push_i(rx_push_i), .rx_data_i(rx_data_i),
    .rx_first_i(rx_first_i), .rx_end_i(rx_end_i), .rx_crc_bad_i(rx_crc_bad_i), .rx_abort_i(rx_abort_i));

  hhfs_engine_model hhfs_engine_model_inst (.ref_clk_i(ref_clk_i), .pop_en_i(pop_en), .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o), .tx_pop_o(tx_pop_i), .tx_sent_o(tx_msg_sent_i),
    .rx_push_o(rx_push_i), .rx_data_o(rx_data_i), .rx_first_o(rx_first_i), .rx_end_o(rx_end_i),
    .rx_crc_bad_o(rx_crc_bad_i), .rx_abort_o(rx_abort_i));

  // 10 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // abort pulses of controller two, counted at the edge where the engine takes them
  always @(posedge ref_clk_i) begin
    if (tx_abort_o[1] === 1'b1) begin
      aborts++;
    end
  end

  // watchdog, about five times the expected run
  initial begin
    #1_000_000;
    fails++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // every access leaves an idle cycle, so no strobe is driven twice in one step
  task automatic wr(input logic [7:0] a, dt, input logic last = 1'b0);
    idle(1);
    addr_i = a;
    wdata_i = dt;
    tx_end_mark_i = {last, last};
    wr_i = 1'b1;
    idle(1);
    wr_i = 1'b0;
    tx_end_mark_i = 2'b00;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] dt);
    idle(1);
    addr_i = a;
    rd_i = 1'b1;
    idle(1);
    rd_i = 1'b0;
    idle(1);
    check("read strobe answer", {7'h00, rd_valid_o}, 8'h01);
    dt = rdata_o;
    idle(1);
  endtask

  task automatic rdc(input logic [7:0] a, exp, input string what);
    logic [7:0] got;
    rd(a, got);
    check(what, got, exp);
  endtask

  task automatic send_pkt(input int n, input logic cb, ab, opn, fin);
    for (int i = 0; i < n; i++) begin
      hhfs_engine_model_inst.push(0, 8'h10 + 8'(i), opn && i == 0, fin && i == n - 1, cb, ab);
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_i, wr_i, rd_i, pop_en, tx_end_mark_i, addr_i, wdata_i} = {1'b1, 22'h0};
    fails = 0;
    checks_done = 0;
    idle(5);
    rst_i = 1'b0;
    foreach (rows[i]) rdc(rows[i][15:8], rows[i][7:0], "reset value");
    // transmit message of two bytes, done event unmasked
    wr(8'h21, 8'h40);
    wr(8'h9D, 8'hA5);
    wr(8'h9D, 8'h3C, 1'b1);
    rdc(8'h9F, 8'h7E, "tx space");
    rdc(8'h2E, 8'h08, "info one not empty");
    pop_en = 2'b01;
    idle(20);
    pop_en = 2'b00;
    check("tx byte", hhfs_engine_model_inst.got_q[0][7:0], 8'hA5);
    check("tx byte", hhfs_engine_model_inst.got_q[1][7:0], 8'h3C);
    check("int on done", {7'h00, int_n_o}, 8'h00);
    rdc(8'h20, 8'h41, "status done");
    check("int cleared", {7'h00, int_n_o}, 8'h01);
    rdc(8'h20, 8'h01, "status after read");
    wr(8'h21, 8'h00);
    // unterminated byte on controller two runs dry
    hhfs_engine_model_inst.got_q.delete();
    wr(8'hAD, 8'h77);
    pop_en = 2'b10;
    idle(12);
    pop_en = 2'b00;
    rdc(8'h2D, 8'h08, "underrun latched");
    rdc(8'h2D, 8'h00, "underrun cleared");
    check("abort count", 8'(aborts), 8'h01);
    // fill transmit two until refused, then drain it
    hhfs_engine_model_inst.got_q.delete();
    for (int i = 0; i < FIFO_DEPTH; i++) wr(8'hAD, 8'(i), i == FIFO_DEPTH - 1);
    wr(8'hAD, 8'hEE);
    rdc(8'h2F, 8'h18, "info two full");
    rdc(8'hAF, 8'h00, "tx space full");
    pop_en = 2'b10;
    idle(540);
    pop_en = 2'b00;
    check("tx count", 8'(hhfs_engine_model_inst.got_q.size()), 8'h80);
    check("tx last", hhfs_engine_model_inst.got_q[$][7:0], 8'h7F);
    rdc(8'h2D, 8'h00, "no underrun");
    check("no abort on drain", 8'(aborts), 8'h01);
    // receive packet endings; host reads count, bytes, then info
    foreach (pkts[k]) begin
      send_pkt(int'(pkts[k][12:5]), pkts[k][4], pkts[k][3], 1'b1, 1'b1);
      rdc(8'h2D, 8'h01, "opening byte");
      rdc(8'h9C, pkts[k][12:5], "rx count");
      for (int i = 0; i < int'(pkts[k][12:5]); i++) rdc(8'h9E, 8'h10 + 8'(i), "rx byte");
      rdc(8'h2E, {5'h05, pkts[k][2:0]}, "packet status");
      rdc(8'h20, 8'h31, "packet end event");
    end
    // rising-edge interrupt, partial count, then overrun
    wr(8'h21, 8'h04);
    send_pkt(10, 1'b0, 1'b0, 1'b1, 1'b0);
    check("int on not empty", {7'h00, int_n_o}, 8'h00);
    rdc(8'h20, 8'h15, "status not empty");
    check("int edge only", {7'h00, int_n_o}, 8'h01);
    rdc(8'h9C, 8'h8A, "count first part");
    rdc(8'h9E, 8'h10, "rx first byte");
    rdc(8'h2E, 8'h20, "in progress");
    send_pkt(125, 1'b0, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < FIFO_DEPTH - 1; i++) rd(8'h9E, rv);
    rdc(8'h2E, 8'h20, "one byte left");
    rd(8'h9E, rv);
    rdc(8'h2E, 8'h2C, "overrun");
    wr(8'h21, 8'h00);
    // reset in mid-run brings every register back
    idle(1);
    rst_i = 1'b1;
    idle(2);
    rst_i = 1'b0;
    foreach (rows[i]) rdc(rows[i][15:8], rows[i][7:0], "reset value again");
    tally_and_finish();
  end
endmodule
